// *** common/iaar_pkg.sv ***
// constants and types for the acknowledge and memory attribute registers
package iaar_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] ACK_OFFSET = 16'h0024;
  localparam logic [15:0] ATTR_OFFSET = 16'h0028;
  // acknowledge register bit positions
  localparam int ACK_XLATE_BIT = 0;
  localparam int ACK_PRIQ_BIT = 1;
  // attribute register field positions (low bit of each two-bit field)
  localparam int TABLE_SHARE_LSB = 10;
  localparam int TABLE_OUTER_LSB = 8;
  localparam int TABLE_INNER_LSB = 6;
  localparam int QUEUE_SHARE_LSB = 4;
  localparam int QUEUE_OUTER_LSB = 2;
  localparam int QUEUE_INNER_LSB = 0;
  localparam int ATTR_USED_W = 12;
  localparam int TABLE_FIELD_LSB = 6;
  localparam int QUEUE_FIELD_LSB = 0;
  localparam int GROUP_W = 6;
  // reset values
  localparam logic ACK_RESET = 1'h0;
  localparam logic [5:0] GROUP_RESET = 6'h00;
  // shareability codes
  localparam logic [1:0] SH_NON = 2'h0;
  localparam logic [1:0] SH_RSVD = 2'h1;
  localparam logic [1:0] SH_OUTER = 2'h2;
  localparam logic [1:0] SH_INNER = 2'h3;
  // cacheability codes
  localparam logic [1:0] CA_NON = 2'h0;
  localparam logic [1:0] CA_WB = 2'h1;
  localparam logic [1:0] CA_WT = 2'h2;
  localparam logic [1:0] CA_RSVD = 2'h3;
  // cycles from an enable change to its acknowledge
  localparam int ACK_LATENCY_CYCLES = 4;
  typedef enum logic [2:0] {
    ACC_STREAM_TABLE,
    ACC_VM_STRUCTURE,
    ACC_COMMAND_QUEUE,
    ACC_EVENT_QUEUE,
    ACC_PAGE_REQUEST_QUEUE
  } iaar_access_e;
endpackage

// *** design/iaar_top.sv ***
// acknowledge and structure memory attribute register block
// Summary of operation
// - page request ack reports queue writes
// - translation ack zero means streams bypass
// - translation ack one means streams checked
// - attribute fields at fixed bit positions
// - shareability decode, reserved acts non-shareable
// - cacheability decode, reserved acts non-cacheable
// - both caches non-cacheable forces outer shareable
// - preset groups reset to chosen value
// - fixed table attributes ignore stored writes
// - fixed queue attributes ignore stored writes
// - table fields writable only when translation off
// - table writes while enabled are ignored
// - queue fields writable only when queues off
// - queue writes while enabled are ignored
// - tables and queues use their own attributes
// - allocation hints only for cacheable types
// - unsupported type aborts, stream table faults
`timescale 1ns/1ps
`default_nettype none
module iaar_top #(
  parameter bit PAGE_REQUEST_IMPLEMENTED = 1'b1,
  parameter int ECMDQ_COUNT = 2,
  parameter bit TABLE_ATTR_FIXED_FLAG = 1'b0,
  parameter bit QUEUE_ATTR_FIXED_FLAG = 1'b0,
  parameter logic [5:0] TABLE_PRESET_VALUE = 6'h3D,
  parameter logic [5:0] QUEUE_PRESET_VALUE = 6'h3D,
  // bit n set when cache code n (non, write-back, write-through) is supported
  parameter logic [2:0] SUPPORTED_CACHE_MASK = 3'h7
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // register port
  input wire logic [iaar_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [31:0] REG_WDATA_IN,
  output logic [31:0] REG_RDATA_OUT,
  // control enables and acknowledges held elsewhere
  input wire logic TRANSLATION_ENABLE_IN,
  input wire logic PAGE_REQUEST_QUEUE_ENABLE_IN,
  input wire logic COMMAND_QUEUE_ENABLE_IN,
  input wire logic COMMAND_QUEUE_ENABLE_ACK_IN,
  input wire logic EVENT_QUEUE_ENABLE_IN,
  input wire logic EVENT_QUEUE_ENABLE_ACK_IN,
  input wire logic [ECMDQ_COUNT-1:0] ENHANCED_CMDQ_ENABLE_IN,
  input wire logic [ECMDQ_COUNT-1:0] ENHANCED_CMDQ_ENABLE_ACK_IN,
  // stream treatment
  output logic BYPASS_OUT,
  output logic CHECK_STREAMS_OUT,
  output logic PAGE_REQUEST_WRITES_OUT,
  // structure access attribute lookup
  input wire logic ACCESS_VALID_IN,
  input wire iaar_pkg::iaar_access_e ACCESS_KIND_IN,
  output logic ACCESS_DONE_OUT,
  output logic [1:0] ACCESS_SHARE_OUT,
  output logic [1:0] ACCESS_OUTER_OUT,
  output logic [1:0] ACCESS_INNER_OUT,
  output logic ACCESS_HINTS_USED_OUT,
  output logic ACCESS_ABORT_OUT,
  output logic STREAM_ENTRY_FETCH_FAULT_OUT
);
  localparam int CNT_W = $clog2(iaar_pkg::ACK_LATENCY_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST =
    CNT_W'(iaar_pkg::ACK_LATENCY_CYCLES - 1);

  // stored attribute groups
  logic [iaar_pkg::GROUP_W-1:0] table_attr;
  logic [iaar_pkg::GROUP_W-1:0] queue_attr;
  // acknowledge bits and their completion counters
  logic [1:0] ack;
  logic [CNT_W-1:0] ack_cnt [2];
  wire [1:0] ack_req;

  // decode
  wire hit_ack = REG_ADDR_IN == iaar_pkg::ACK_OFFSET;
  wire hit_attr = REG_ADDR_IN == iaar_pkg::ATTR_OFFSET;
  wire wr_attr = REG_WR_IN && hit_attr;
  wire xlate_ack = ack[iaar_pkg::ACK_XLATE_BIT];
  wire priq_ack = ack[iaar_pkg::ACK_PRIQ_BIT];

  // guard conditions
  wire table_open = !TRANSLATION_ENABLE_IN && !xlate_ack;
  // each queue counts as busy while either its enable or its ack is set,
  // so a queue still shutting down keeps the fields locked
  wire event_closed =
    !EVENT_QUEUE_ENABLE_IN && !EVENT_QUEUE_ENABLE_ACK_IN;
  wire cmd_closed =
    !COMMAND_QUEUE_ENABLE_IN && !COMMAND_QUEUE_ENABLE_ACK_IN;
  wire priq_closed =
    !PAGE_REQUEST_QUEUE_ENABLE_IN && !priq_ack;
  wire ecmdq_closed =
    !(|ENHANCED_CMDQ_ENABLE_IN) && !(|ENHANCED_CMDQ_ENABLE_ACK_IN);
  wire queue_open =
    event_closed && cmd_closed && priq_closed && ecmdq_closed;

  // writes while guarded are dropped, never deferred
  wire table_we = wr_attr && table_open;
  wire queue_we = wr_attr && queue_open;
  wire [iaar_pkg::GROUP_W-1:0] wr_table =
    REG_WDATA_IN[iaar_pkg::TABLE_FIELD_LSB +: iaar_pkg::GROUP_W];
  wire [iaar_pkg::GROUP_W-1:0] wr_queue =
    REG_WDATA_IN[iaar_pkg::QUEUE_FIELD_LSB +: iaar_pkg::GROUP_W];
  wire [iaar_pkg::GROUP_W-1:0] next_table_attr =
    table_we ? wr_table : table_attr;
  wire [iaar_pkg::GROUP_W-1:0] next_queue_attr =
    queue_we ? wr_queue : queue_attr;

  // a fixed group stores what is written but keeps its preset effect
  wire [iaar_pkg::GROUP_W-1:0] table_eff =
    TABLE_ATTR_FIXED_FLAG ? TABLE_PRESET_VALUE : table_attr;
  wire [iaar_pkg::GROUP_W-1:0] queue_eff =
    QUEUE_ATTR_FIXED_FLAG ? QUEUE_PRESET_VALUE : queue_attr;

  function automatic logic [1:0] cache_norm(input logic [1:0] code);
    cache_norm = (code == iaar_pkg::CA_RSVD) ? iaar_pkg::CA_NON : code;
  endfunction

  function automatic logic [1:0] share_norm(input logic [1:0] sh,
                                            input logic [1:0] oc,
                                            input logic [1:0] ic);
    logic [1:0] coc;
    logic [1:0] cic;
    coc = cache_norm(oc);
    cic = cache_norm(ic);
    if (coc == iaar_pkg::CA_NON && cic == iaar_pkg::CA_NON) begin
      share_norm = iaar_pkg::SH_OUTER;
    end else if (sh == iaar_pkg::SH_RSVD) begin
      share_norm = iaar_pkg::SH_NON;
    end else begin
      share_norm = sh;
    end
  endfunction

  function automatic logic supported(input logic [1:0] code);
    supported = SUPPORTED_CACHE_MASK[cache_norm(code)];
  endfunction

  // pick the group that governs this kind of access
  wire use_table = ACCESS_KIND_IN == iaar_pkg::ACC_STREAM_TABLE ||
    ACCESS_KIND_IN == iaar_pkg::ACC_VM_STRUCTURE;
  wire [iaar_pkg::GROUP_W-1:0] grp = use_table ? table_eff : queue_eff;
  // group layout is sh, oc, ic from high to low
  wire [1:0] grp_sh = grp[5:4];
  wire [1:0] grp_oc = grp[3:2];
  wire [1:0] grp_ic = grp[1:0];
  wire [1:0] next_share = share_norm(grp_sh, grp_oc, grp_ic);
  wire [1:0] next_outer = cache_norm(grp_oc);
  wire [1:0] next_inner = cache_norm(grp_ic);
  wire next_hints = next_outer != iaar_pkg::CA_NON ||
    next_inner != iaar_pkg::CA_NON;
  wire next_abort = ACCESS_VALID_IN &&
    !(supported(grp_oc) && supported(grp_ic));
  wire is_stream_table = ACCESS_KIND_IN == iaar_pkg::ACC_STREAM_TABLE;
  wire next_entry_fault = next_abort && is_stream_table;

  // read data; reserved bits read zero
  wire [31:0] ack_word = {30'h0, priq_ack, xlate_ack};
  wire [31:0] attr_word = {20'h0, table_attr, queue_attr};
  // unmapped offsets read zero rather than holding stale data
  wire [31:0] mapped_word =
    hit_ack ? ack_word : hit_attr ? attr_word : 32'h0;
  // idle cycles keep the last read so software may sample late
  wire [31:0] next_rdata = REG_RD_IN ? mapped_word : REG_RDATA_OUT;

  // acknowledge requests; PAGE_REQUEST_IMPLEMENTED clear keeps its bit at zero
  assign ack_req[iaar_pkg::ACK_XLATE_BIT] = TRANSLATION_ENABLE_IN;
  assign ack_req[iaar_pkg::ACK_PRIQ_BIT] =
    PAGE_REQUEST_IMPLEMENTED && PAGE_REQUEST_QUEUE_ENABLE_IN;

  // acks have no write path; each follows its enable after the change
  // completes, and a request that flips back restarts the wait
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ack
      wire pending = ack_req[gi] != ack[gi];
      wire done = pending && ack_cnt[gi] == CNT_LAST;
      wire [CNT_W-1:0] next_cnt =
        (!pending || done) ? '0 : CNT_W'(ack_cnt[gi] + 1'b1);
      always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          ack[gi] <= iaar_pkg::ACK_RESET;
          ack_cnt[gi] <= '0;
        end else begin
          ack_cnt[gi] <= next_cnt;
          if (done) begin
            ack[gi] <= ack_req[gi];
          end
        end
      end
    end
  endgenerate

  // non-preset groups reset to zero so software sees a defined value
  // reset values are constant parameters, so the async branch stays clean
  localparam logic [iaar_pkg::GROUP_W-1:0] TABLE_RESET =
    TABLE_ATTR_FIXED_FLAG ? TABLE_PRESET_VALUE : iaar_pkg::GROUP_RESET;
  localparam logic [iaar_pkg::GROUP_W-1:0] QUEUE_RESET =
    QUEUE_ATTR_FIXED_FLAG ? QUEUE_PRESET_VALUE : iaar_pkg::GROUP_RESET;

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      table_attr <= TABLE_RESET;
    end else begin
      table_attr <= next_table_attr;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      queue_attr <= QUEUE_RESET;
    end else begin
      queue_attr <= next_queue_attr;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      REG_RDATA_OUT <= 32'h0;
    end else begin
      REG_RDATA_OUT <= next_rdata;
    end
  end

  // stream treatment follows the acknowledge, not the raw enable
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      BYPASS_OUT <= 1'b1;
      CHECK_STREAMS_OUT <= 1'b0;
    end else begin
      BYPASS_OUT <= !xlate_ack;
      CHECK_STREAMS_OUT <= xlate_ack;
    end
  end

  // queue writes are reported only once the enable has fully completed
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      PAGE_REQUEST_WRITES_OUT <= 1'b0;
    end else begin
      PAGE_REQUEST_WRITES_OUT <= priq_ack;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ACCESS_DONE_OUT <= 1'b0;
      ACCESS_ABORT_OUT <= 1'b0;
      STREAM_ENTRY_FETCH_FAULT_OUT <= 1'b0;
    end else begin
      ACCESS_DONE_OUT <= ACCESS_VALID_IN;
      ACCESS_ABORT_OUT <= next_abort;
      STREAM_ENTRY_FETCH_FAULT_OUT <= next_entry_fault;
    end
  end

  // lookup data holds between requests; only the pulses drop each cycle
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ACCESS_SHARE_OUT <= iaar_pkg::SH_NON;
      ACCESS_OUTER_OUT <= iaar_pkg::CA_NON;
      ACCESS_INNER_OUT <= iaar_pkg::CA_NON;
      ACCESS_HINTS_USED_OUT <= 1'b0;
    end else begin
      if (ACCESS_VALID_IN) begin
        ACCESS_SHARE_OUT <= next_share;
        ACCESS_OUTER_OUT <= next_outer;
        ACCESS_INNER_OUT <= next_inner;
        ACCESS_HINTS_USED_OUT <= next_hints;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/iaar_top_bench.sv ***
// self-checking bench for the ack and attribute register block
`timescale 1ns/1ps
`default_nettype none
module iaar_top_bench;
  localparam logic [15:0] ACK = iaar_pkg::ACK_OFFSET;
  localparam logic [15:0] ATR = iaar_pkg::ATTR_OFFSET;
  logic CLK_IN = 1'b0, RSTN_IN = 1'b0, REG_WR_IN = 1'b0, REG_RD_IN = 1'b0;
  logic [15:0] REG_ADDR_IN = 16'h0000;
  logic [31:0] REG_WDATA_IN = 32'h0, REG_RDATA_OUT;
  logic TRANSLATION_ENABLE_IN = 1'b0, ACCESS_VALID_IN = 1'b0;
  iaar_pkg::iaar_access_e ACCESS_KIND_IN = iaar_pkg::ACC_STREAM_TABLE;
  // one bit per queue guard so a loop walks them all
  logic [8:0] guard = 9'h000;
  wire logic COMMAND_QUEUE_ENABLE_IN = guard[0];
  wire logic COMMAND_QUEUE_ENABLE_ACK_IN = guard[1];
  wire logic EVENT_QUEUE_ENABLE_IN = guard[2];
  wire logic EVENT_QUEUE_ENABLE_ACK_IN = guard[3];
  wire logic [1:0] ENHANCED_CMDQ_ENABLE_IN = guard[5:4];
  wire logic [1:0] ENHANCED_CMDQ_ENABLE_ACK_IN = guard[7:6];
  wire logic PAGE_REQUEST_QUEUE_ENABLE_IN = guard[8];
  logic BYPASS_OUT, CHECK_STREAMS_OUT, PAGE_REQUEST_WRITES_OUT, ACCESS_DONE_OUT;
  logic ACCESS_HINTS_USED_OUT, ACCESS_ABORT_OUT, STREAM_ENTRY_FETCH_FAULT_OUT;
  logic [1:0] ACCESS_SHARE_OUT, ACCESS_OUTER_OUT, ACCESS_INNER_OUT;
  int err_count = 0, cmp_count = 0;
  // write-through left unsupported so aborts can be seen
  iaar_top #(.SUPPORTED_CACHE_MASK(3'h3)) iaar_top_inst (.*);
  always #50 CLK_IN = ~CLK_IN;
  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge CLK_IN);
    REG_ADDR_IN = a;
    REG_WDATA_IN = d;
    REG_WR_IN = 1'b1;
    @(negedge CLK_IN);
    REG_WR_IN = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge CLK_IN);
    REG_ADDR_IN = a;
    REG_RD_IN = 1'b1;
    @(negedge CLK_IN);
    REG_RD_IN = 1'b0;
    d = REG_RDATA_OUT;
  endtask
  task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(nm, d, e);
  endtask
  // ack completion is awaited by polling, bounded
  task automatic wait_ack(input int b, input logic v);
    logic [31:0] d;
    for (int n = 0; n < 12; n++) begin
      rd(ACK, d);
      if (d[b] === v) return;
    end
    check("ack wait", d[b], v);
    print_verdict();
  endtask
  function automatic logic [6:0] norm(input logic [5:0] g);
    logic [1:0] s, o, i;
    o = (g[3:2] == 2'h3) ? 2'h0 : g[3:2];
    i = (g[1:0] == 2'h3) ? 2'h0 : g[1:0];
    s = (g[5:4] == 2'h1) ? 2'h0 : g[5:4];
    if (o == 2'h0 && i == 2'h0) s = 2'h2;
    return {o != 2'h0 || i != 2'h0, s, o, i};
  endfunction
  task automatic acc(input int k, input logic [5:0] g);
    logic [6:0] e;
    logic ab;
    e = norm(g);
    ab = e[3:2] == 2'h2 || e[1:0] == 2'h2;
    @(negedge CLK_IN);
    ACCESS_KIND_IN = iaar_pkg::iaar_access_e'(k);
    ACCESS_VALID_IN = 1'b1;
    @(negedge CLK_IN);
    ACCESS_VALID_IN = 1'b0;
    check("done", ACCESS_DONE_OUT, 1'b1);
    check("attr", {ACCESS_HINTS_USED_OUT, ACCESS_SHARE_OUT, ACCESS_OUTER_OUT,
      ACCESS_INNER_OUT}, e);
    check("abort", {ACCESS_ABORT_OUT, STREAM_ENTRY_FETCH_FAULT_OUT},
      {ab, ab && k == 0});
  endtask
  task automatic t_reset_regs();
    check("bypass", {BYPASS_OUT, CHECK_STREAMS_OUT, PAGE_REQUEST_WRITES_OUT}, 3'h4);
    rchk("ack reset", ACK, 32'h0);
    rchk("attr reset", ATR, 32'h0);
    wr(ATR, 32'hFFFF_FFFF);
    rchk("attr all", ATR, 32'h0000_0FFF);
    wr(ACK, 32'hFFFF_FFFF);
    rchk("ack ro", ACK, 32'h0);
    rchk("unmapped", 16'h0030, 32'h0);
    $display("test reset_regs done");
  endtask
  task automatic t_decode();
    for (int n = 0; n < 64; n++) begin
      wr(ATR, {20'h0, n[5:0], ~n[5:0]});
      for (int k = 0; k < 5; k++) acc(k, (k < 2) ? n[5:0] : ~n[5:0]);
    end
    $display("test decode done");
  endtask
  task automatic t_xlate();
    wr(ATR, 32'h0);
    @(negedge CLK_IN);
    TRANSLATION_ENABLE_IN = 1'b1;
    wait_ack(0, 1'b1);
    check("check on", {BYPASS_OUT, CHECK_STREAMS_OUT}, 2'h1);
    wr(ATR, 32'h0000_0FFF);
    rchk("table locked", ATR, 32'h0000_003F);
    @(negedge CLK_IN);
    TRANSLATION_ENABLE_IN = 1'b0;
    wr(ATR, 32'h0000_0FC0);
    rchk("ack still on", ATR, 32'h0);
    wait_ack(0, 1'b0);
    check("bypass on", {BYPASS_OUT, CHECK_STREAMS_OUT}, 2'h2);
    wr(ATR, 32'h0000_0FC0);
    rchk("table open", ATR, 32'h0000_0FC0);
    $display("test xlate done");
  endtask
  task automatic t_queue();
    for (int b = 0; b < 9; b++) begin
      wait_ack(1, 1'b0);
      wr(ATR, 32'h0);
      @(negedge CLK_IN);
      guard[b] = 1'b1;
      wr(ATR, 32'h0000_0FFF);
      rchk("queue locked", ATR, 32'h0000_0FC0);
      guard = 9'h000;
    end
    wait_ack(1, 1'b0);
    wr(ATR, 32'h0);
    @(negedge CLK_IN);
    guard[8] = 1'b1;
    wait_ack(1, 1'b1);
    check("pri writes", PAGE_REQUEST_WRITES_OUT, 1'b1);
    guard = 9'h000;
    wr(ATR, 32'h0000_0FFF);
    rchk("pri ack lock", ATR, 32'h0000_0FC0);
    wait_ack(1, 1'b0);
    check("pri off", PAGE_REQUEST_WRITES_OUT, 1'b0);
    $display("test queue done");
  endtask
  initial begin
    repeat (8) @(posedge CLK_IN);
    @(negedge CLK_IN);
    RSTN_IN = 1'b1;
    t_reset_regs();
    t_decode();
    t_xlate();
    t_queue();
    print_verdict();
  end
endmodule
`default_nettype wire

// *** test/iaar_top_sva.sv ***
// assertions for the ack and attribute register block
`timescale 1ns/1ps
`default_nettype none
module iaar_sva (
  // clock, reset, register port
  input wire logic CLK_IN, RSTN_IN, REG_RD_IN,
  input wire logic [31:0] REG_RDATA_OUT,
  // enables and stream treatment
  input wire logic TRANSLATION_ENABLE_IN, PAGE_REQUEST_QUEUE_ENABLE_IN,
  input wire logic BYPASS_OUT, CHECK_STREAMS_OUT, PAGE_REQUEST_WRITES_OUT,
  // access lookup
  input wire logic ACCESS_VALID_IN, ACCESS_DONE_OUT, ACCESS_HINTS_USED_OUT,
  input wire logic ACCESS_ABORT_OUT, STREAM_ENTRY_FETCH_FAULT_OUT,
  input wire logic [1:0] ACCESS_SHARE_OUT, ACCESS_OUTER_OUT, ACCESS_INNER_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // enable held long enough for the ack to complete
  sequence xl_held;
    $rose(TRANSLATION_ENABLE_IN) ##0 TRANSLATION_ENABLE_IN [*5];
  endsequence
  sequence pq_held;
    $rose(PAGE_REQUEST_QUEUE_ENABLE_IN) ##0 PAGE_REQUEST_QUEUE_ENABLE_IN [*5];
  endsequence
  a_xlate_ack_on: assert property (xl_held |=> !BYPASS_OUT)
    else $error("bypass still set after enable completed");
  a_xlate_not_early: assert property (
    $rose(TRANSLATION_ENABLE_IN) && BYPASS_OUT |-> BYPASS_OUT [*5])
    else $error("bypass dropped before ack latency");
  a_pri_ack_on: assert property (pq_held |=> PAGE_REQUEST_WRITES_OUT)
    else $error("page request writes not reported");
  a_bypass_check_pair: assert property (BYPASS_OUT != CHECK_STREAMS_OUT)
    else $error("bypass and check agree");
  a_read_upper_zero: assert property (
    REG_RD_IN |=> REG_RDATA_OUT[31:12] == 20'h0)
    else $error("reserved read bits not zero");
  a_done_one_later: assert property (ACCESS_VALID_IN |=> ACCESS_DONE_OUT)
    else $error("lookup done missing");
  a_share_not_rsvd: assert property (
    ACCESS_DONE_OUT |-> ACCESS_SHARE_OUT != 2'h1)
    else $error("reserved shareability returned");
  a_cache_not_rsvd: assert property (
    ACCESS_DONE_OUT |-> ACCESS_OUTER_OUT != 2'h3 && ACCESS_INNER_OUT != 2'h3)
    else $error("reserved cacheability returned");
  a_nc_outer_share: assert property (
    ACCESS_DONE_OUT && ACCESS_OUTER_OUT == 2'h0 && ACCESS_INNER_OUT == 2'h0
    |-> ACCESS_SHARE_OUT == 2'h2)
    else $error("non-cacheable access not outer shareable");
  a_hints_cacheable: assert property (ACCESS_DONE_OUT |->
    ACCESS_HINTS_USED_OUT == (ACCESS_OUTER_OUT != 2'h0 || ACCESS_INNER_OUT != 2'h0))
    else $error("allocation hints used wrongly");
  a_fault_on_abort: assert property (
    STREAM_ENTRY_FETCH_FAULT_OUT |-> ACCESS_ABORT_OUT && ACCESS_DONE_OUT)
    else $error("fetch fault without abort");
endmodule
bind iaar_top iaar_sva iaar_sva_inst (.*);
`default_nettype wire
